// ---- rtl/ocfr_pkg.sv ----
// Operation
// - The fault response setting is an eight-bit value the host writes and reads as one byte at command 0x47.
// - Every response code sets the over-current status bit on detection and notifies the host.
// - Code 00 keeps running indefinitely with the current held at the fault threshold, whatever the voltage does.
// - Code 01 holds the current only while the output stays above the cutoff, else shuts down and follows the retry count.
// - Code 10 limits current for the programmed delay, then applies the retry policy if still limiting.
// - Code 11 shuts the output down at once and then follows the retry count.
// - Retry count 000 makes no restart and keeps the output off until the fault is cleared.
// - Retry counts 001 to 110 allow that many restarts, then hold the output off until the fault is cleared.
// - Starts of successive restart attempts are spaced by the delay count times the delay time unit.
// - Retry count 111 retries without limit until commanded off, power is removed or another fault stops it.
// - The delay field n selects 2 to the power n time units, from 1 up to 128.
// - One delay count serves both the limiting interval and the restart spacing; the unit length is external.
// - A latched fault clears on an individual status clear, a clear-all command, an off-on cycle or power loss.
// - The current-limit level comes from the host-writable sixteen-bit threshold at command 0x46.
// - The low-voltage cutoff comes from the host-writable sixteen-bit threshold at command 0x48.
package ocfr_pkg;

	// ----------------------------------------
	// Command codes
	// ----------------------------------------
	localparam logic [7:0]  CMD_CURRENT_LIMIT = 8'h46;
	localparam logic [7:0]  CMD_OC_RESPONSE   = 8'h47;
	localparam logic [7:0]  CMD_LV_CUTOFF     = 8'h48;

	// ----------------------------------------
	// Response byte layout
	// ----------------------------------------
	localparam int          RESP_HI           = 7;
	localparam int          RESP_LO           = 6;
	localparam int          RETRY_HI          = 5;
	localparam int          RETRY_LO          = 3;
	localparam int          DELAY_HI          = 2;
	localparam int          DELAY_LO          = 0;

	localparam logic [1:0]  RESP_CONST_CUR    = 2'h0;
	localparam logic [1:0]  RESP_COND_CUR     = 2'h1;
	localparam logic [1:0]  RESP_DELAY_CUR    = 2'h2;
	localparam logic [1:0]  RESP_SHUTDOWN     = 2'h3;

	localparam logic [2:0]  RETRY_NONE        = 3'h0;
	localparam logic [2:0]  RETRY_ENDLESS     = 3'h7;

	// ----------------------------------------
	// Reset values and timing
	// ----------------------------------------
	localparam logic [7:0]  RESPONSE_RESET    = 8'hc0;
	localparam logic [15:0] CUR_LIMIT_RESET   = 16'h0000;
	localparam logic [15:0] LV_CUTOFF_RESET   = 16'h0000;
	localparam logic [7:0]  ONE_UNIT          = 8'h01;
	localparam logic [7:0]  ZERO_UNITS        = 8'h00;
	localparam logic [2:0]  ZERO_ATTEMPTS     = 3'h0;
	localparam logic [2:0]  ONE_ATTEMPT       = 3'h1;

	// ----------------------------------------
	// Fault sequencer states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_OFF_CMD,
		ST_RUN,
		ST_LIMIT,
		ST_DELAY_CC,
		ST_OFF_WAIT,
		ST_RESTART,
		ST_LATCHED
	} ocfr_state_t;

endpackage

// ---- rtl/ocfr_unit_tick.sv ----
`timescale 1ns/1ps
module ocfr_unit_tick import ocfr_pkg::*; #(
	parameter int UNIT_W = 16
) (
	// Clock and reset
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	// Control
	input  wire logic              restart_in,
	input  wire logic [UNIT_W-1:0] unit_cycles_in,
	// Enable pulse
	output wire logic              tick_out
);

	// ----------------------------------------
	// Divider
	// ----------------------------------------
	logic [UNIT_W-1:0] count;
	wire  [UNIT_W:0]   count_plus = {1'b0, count} + {{UNIT_W{1'b0}}, 1'b1};

	// Zero length acts as one cycle, never a stall
	assign tick_out = count_plus >= {1'b0, unit_cycles_in};

	always_ff @(posedge clk_in) begin
		if (rst_in || restart_in || tick_out) begin
			count <= '0;
		end else begin
			count <= count_plus[UNIT_W-1:0];
		end
	end

endmodule

// ---- rtl/ocfr_delay_timer.sv ----
`timescale 1ns/1ps
module ocfr_delay_timer import ocfr_pkg::*; (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	// Control
	input  wire logic       start_in,
	input  wire logic [7:0] units_in,
	input  wire logic       tick_in,
	// Status
	output wire logic       expired_out
);

	// ----------------------------------------
	// Unit countdown
	// ----------------------------------------
	logic [7:0] units_left;
	logic       armed;

	// Expiry shows on the last tick, else every restart start slips a cycle
	assign expired_out = armed && ((units_left == ZERO_UNITS) || (tick_in && units_left == ONE_UNIT));

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			units_left <= ZERO_UNITS;
			armed      <= 1'b0;
		end else if (start_in) begin
			units_left <= units_in;
			armed      <= 1'b1;
		end else if (tick_in && units_left != ZERO_UNITS) begin
			units_left <= units_left - ONE_UNIT;
		end
	end

endmodule

// ---- rtl/ocfr_core.sv ----
`timescale 1ns/1ps
module ocfr_core import ocfr_pkg::*; #(
	parameter int UNIT_W = 16
) (
	// Clock and reset
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	// Management command port
	input  wire logic              cmd_valid_in,
	input  wire logic              cmd_write_in,
	input  wire logic [7:0]        cmd_code_in,
	input  wire logic [15:0]       cmd_wdata_in,
	output logic      [15:0]       rdata_out,
	output logic                   rdata_valid_out,
	output logic                   cmd_unsupported_out,
	// Fault clearing and control
	input  wire logic              status_clear_in,
	input  wire logic              clear_faults_in,
	input  wire logic              output_on_cmd_in,
	input  wire logic              other_fault_in,
	// Delay time unit
	input  wire logic [UNIT_W-1:0] unit_cycles_in,
	// Power stage sensing
	input  wire logic              oc_detect_in,
	input  wire logic              limiting_in,
	input  wire logic              vout_low_in,
	// Power stage control
	output logic                   output_enable_out,
	output logic                   current_limit_en_out,
	output logic      [15:0]       current_fault_threshold_out,
	output logic      [15:0]       low_voltage_cutoff_threshold_out,
	// Status
	output logic                   oc_fault_status_out,
	output logic                   fault_notify_out,
	output logic      [2:0]        attempt_count_out
);

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	logic [7:0]  overcurrent_fault_response;
	logic [15:0] current_fault_threshold;
	logic [15:0] low_voltage_cutoff_threshold;

	wire hit_limit = cmd_code_in == CMD_CURRENT_LIMIT;
	wire hit_resp  = cmd_code_in == CMD_OC_RESPONSE;
	wire hit_lv    = cmd_code_in == CMD_LV_CUTOFF;
	wire hit_any   = hit_limit || hit_resp || hit_lv;
	wire do_write  = cmd_valid_in && cmd_write_in;
	wire do_read   = cmd_valid_in && !cmd_write_in;

	wire [15:0] next_rdata = hit_resp  ? {8'h00, overcurrent_fault_response} :
	                         hit_limit ? current_fault_threshold :
	                         hit_lv    ? low_voltage_cutoff_threshold : 16'h0000;

	// ----------------------------------------
	// Settings registers
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			overcurrent_fault_response   <= RESPONSE_RESET;
			current_fault_threshold      <= CUR_LIMIT_RESET;
			low_voltage_cutoff_threshold <= LV_CUTOFF_RESET;
		end else if (do_write) begin
			if (hit_resp) begin
				overcurrent_fault_response <= cmd_wdata_in[7:0];
			end
			if (hit_limit) begin
				current_fault_threshold <= cmd_wdata_in;
			end
			if (hit_lv) begin
				low_voltage_cutoff_threshold <= cmd_wdata_in;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rdata_out           <= 16'h0000;
			rdata_valid_out     <= 1'b0;
			cmd_unsupported_out <= 1'b0;
		end else begin
			if (do_read && hit_any) begin
				rdata_out <= next_rdata;
			end
			rdata_valid_out     <= do_read && hit_any;
			cmd_unsupported_out <= cmd_valid_in && !hit_any;
		end
	end

	// limit and cutoff levels to the analog loop
	assign current_fault_threshold_out      = current_fault_threshold;
	assign low_voltage_cutoff_threshold_out = low_voltage_cutoff_threshold;

	// ----------------------------------------
	// Captured setting
	// ----------------------------------------
	ocfr_state_t state;
	ocfr_state_t next_state;
	logic [7:0]  captured_resp;
	logic [2:0]  attempts;
	logic        on_q;
	logic        timer_start;
	logic        fault_event;
	logic        capture;
	logic        count_inc;
	logic        count_clr;
	wire         timer_expired;
	wire         unit_tick;

	wire [7:0] sel_resp    = (state == ST_RUN) ? overcurrent_fault_response : captured_resp;
	wire [1:0] sel_code    = sel_resp[RESP_HI:RESP_LO];
	wire [2:0] sel_retries = sel_resp[RETRY_HI:RETRY_LO];
	wire [2:0] sel_delay   = sel_resp[DELAY_HI:DELAY_LO];
	wire [7:0] delay_units = ONE_UNIT << sel_delay;

	wire clear_req = status_clear_in || clear_faults_in;
	wire turn_on   = output_on_cmd_in && !on_q;
	wire no_retry  = sel_retries == RETRY_NONE;
	// budget used; endless never runs out
	wire spent     = (sel_retries != RETRY_ENDLESS) && (attempts >= sel_retries);

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	// one unit divider for every interval
	ocfr_unit_tick #(
		.UNIT_W         (UNIT_W)
	) u_tick (
		.clk_in         (clk_in),
		.rst_in         (rst_in),
		.restart_in     (timer_start),
		.unit_cycles_in (unit_cycles_in),
		.tick_out       (unit_tick)
	);

	// same count for limiting and spacing
	ocfr_delay_timer u_timer (
		.clk_in      (clk_in),
		.rst_in      (rst_in),
		.start_in    (timer_start),
		.units_in    (delay_units),
		.tick_in     (unit_tick),
		.expired_out (timer_expired)
	);

	// ----------------------------------------
	// Fault sequencer
	// ----------------------------------------
	always_comb begin
		next_state  = state;
		timer_start = 1'b0;
		fault_event = 1'b0;
		capture     = 1'b0;
		count_inc   = 1'b0;
		count_clr   = 1'b0;
		if (!output_on_cmd_in) begin
			next_state = ST_OFF_CMD;
			count_clr  = 1'b1;
		end else if (other_fault_in && (state == ST_OFF_WAIT || state == ST_RESTART)) begin
			next_state = ST_LATCHED;
		end else begin
			unique case (state)
				ST_OFF_CMD: begin
					next_state = ST_RUN;
				end
				ST_RUN: begin
					if (oc_detect_in) begin
						fault_event = 1'b1;
						capture     = 1'b1;
						count_clr   = 1'b1;
						unique case (sel_code)
							RESP_CONST_CUR: next_state = ST_LIMIT;
							RESP_COND_CUR:  next_state = ST_LIMIT;
							RESP_DELAY_CUR: begin
								next_state  = ST_DELAY_CC;
								timer_start = 1'b1;
							end
							RESP_SHUTDOWN: begin
								next_state  = no_retry ? ST_LATCHED : ST_OFF_WAIT;
								timer_start = !no_retry;
							end
						endcase
					end
				end
				ST_LIMIT: begin
					if (sel_code == RESP_COND_CUR && vout_low_in) begin
						next_state  = no_retry ? ST_LATCHED : ST_OFF_WAIT;
						timer_start = !no_retry;
					end else if (!limiting_in) begin
						next_state = ST_RUN;
					end
				end
				ST_DELAY_CC: begin
					if (!limiting_in) begin
						next_state = ST_RUN;
					end else if (timer_expired) begin
						next_state  = no_retry ? ST_LATCHED : ST_OFF_WAIT;
						timer_start = !no_retry;
					end
				end
				ST_OFF_WAIT: begin
					if (timer_expired) begin
						// next start one delay after the last
						next_state  = ST_RESTART;
						timer_start = 1'b1;
						count_inc   = 1'b1;
					end
				end
				ST_RESTART: begin
					if (oc_detect_in) begin
						fault_event = 1'b1;
						next_state  = spent ? ST_LATCHED : ST_OFF_WAIT;
					end else if (timer_expired) begin
						next_state = ST_RUN;
						count_clr  = 1'b1;
					end
				end
				ST_LATCHED: begin
					if (clear_req) begin
						next_state = ST_RUN;
						count_clr  = 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state         <= ST_OFF_CMD;
			captured_resp <= RESPONSE_RESET;
			on_q          <= 1'b0;
		end else begin
			state <= next_state;
			on_q  <= output_on_cmd_in;
			if (capture) begin
				captured_resp <= overcurrent_fault_response;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in || count_clr) begin
			attempts <= ZERO_ATTEMPTS;
		end else if (count_inc) begin
			attempts <= attempts + ONE_ATTEMPT;
		end
	end

	// ----------------------------------------
	// Status and outputs
	// ----------------------------------------
	// Set beats a clear arriving in the same cycle
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			oc_fault_status_out <= 1'b0;
			fault_notify_out    <= 1'b0;
		end else begin
			if (fault_event) begin
				oc_fault_status_out <= 1'b1;
			end else if (clear_req || turn_on) begin
				oc_fault_status_out <= 1'b0;
			end
			fault_notify_out <= fault_event;
		end
	end

	// Enable and limit outputs follow next state to save a cycle of overload; attempt count follows the registered attempts
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			output_enable_out    <= 1'b0;
			current_limit_en_out <= 1'b0;
			attempt_count_out    <= ZERO_ATTEMPTS;
		end else begin
			output_enable_out    <= next_state == ST_RUN || next_state == ST_LIMIT ||
			                        next_state == ST_DELAY_CC || next_state == ST_RESTART;
			current_limit_en_out <= next_state == ST_LIMIT || next_state == ST_DELAY_CC;
			attempt_count_out    <= attempts;
		end
	end

endmodule

// ---- dv/ocfr_core_properties.sv ----
`timescale 1ns/1ps
module ocfr_core_properties import ocfr_pkg::*; (
	// Clock and reset
	input wire logic        clk_in,
	input wire logic        rst_in,
	// Inputs watched
	input wire logic        cmd_valid_in,
	input wire logic        cmd_write_in,
	input wire logic [7:0]  cmd_code_in,
	input wire logic [15:0] cmd_wdata_in,
	input wire logic        output_on_cmd_in,
	input wire logic        oc_detect_in,
	input wire logic        other_fault_in,
	// Outputs watched
	input wire logic        rdata_valid_out,
	input wire logic        cmd_unsupported_out,
	input wire logic        output_enable_out,
	input wire logic        current_limit_en_out,
	input wire logic [15:0] current_fault_threshold_out,
	input wire logic        oc_fault_status_out,
	input wire logic        fault_notify_out,
	input wire logic [2:0]  attempt_count_out
);
	// ----
	// Shadow of the response byte
	// ----
	// Only valid while the bench writes it outside fault sequences
	logic [7:0] resp;
	wire        known   = cmd_code_in inside {CMD_CURRENT_LIMIT, CMD_OC_RESPONSE, CMD_LV_CUTOFF};
	wire        wr_resp = cmd_valid_in && cmd_write_in && cmd_code_in == CMD_OC_RESPONSE;
	wire        hit_run = output_enable_out && !current_limit_en_out && oc_detect_in && output_on_cmd_in;

	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);

	always_ff @(posedge clk_in) begin
		if (rst_in)
			resp <= RESPONSE_RESET;
		else if (wr_resp)
			resp <= cmd_wdata_in[7:0];
	end

	// ----
	// Properties
	// ----
	a_read_answer: assert property (cmd_valid_in && !cmd_write_in && known |=> rdata_valid_out && !cmd_unsupported_out)
		else $error("read of a known code gave no data");
	a_unknown_refused: assert property (cmd_valid_in && !known |=> cmd_unsupported_out && !rdata_valid_out)
		else $error("unknown code not refused");
	a_notify_status: assert property (fault_notify_out |-> oc_fault_status_out)
		else $error("notify without status bit");
	a_detect_notify: assert property (hit_run && !other_fault_in |=> fault_notify_out)
		else $error("detection not notified");
	a_const_keep: assert property (resp[7:6] == RESP_CONST_CUR && hit_run && !other_fault_in
		|=> output_enable_out && current_limit_en_out)
		else $error("constant current did not keep running");
	a_shutdown_now: assert property (resp[7:6] == RESP_SHUTDOWN && hit_run |=> !output_enable_out)
		else $error("shutdown code left output on");
	a_retry_none: assert property (resp[5:3] == RETRY_NONE && oc_fault_status_out && !output_enable_out
		&& output_on_cmd_in |=> !output_enable_out || !oc_fault_status_out)
		else $error("restart with no retries");
	a_attempt_bound: assert property (fault_notify_out && resp[5:3] != RETRY_ENDLESS
		|-> attempt_count_out <= resp[5:3])
		else $error("attempts beyond retry count");
	a_threshold_write: assert property (cmd_valid_in && cmd_write_in && cmd_code_in == CMD_CURRENT_LIMIT
		|=> current_fault_threshold_out == $past(cmd_wdata_in))
		else $error("threshold not stored");

	c_latched: cover property (oc_fault_status_out && !output_enable_out && output_on_cmd_in);
	c_restart: cover property ($rose(output_enable_out) && oc_fault_status_out);
	c_limiting: cover property (current_limit_en_out && output_enable_out);
endmodule

bind ocfr_core ocfr_core_properties ocfr_core_properties_inst (
	.clk_in(clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in), .cmd_write_in(cmd_write_in),
	.cmd_code_in(cmd_code_in), .cmd_wdata_in(cmd_wdata_in), .output_on_cmd_in(output_on_cmd_in),
	.oc_detect_in(oc_detect_in), .other_fault_in(other_fault_in), .rdata_valid_out(rdata_valid_out),
	.cmd_unsupported_out(cmd_unsupported_out), .output_enable_out(output_enable_out),
	.current_limit_en_out(current_limit_en_out), .current_fault_threshold_out(current_fault_threshold_out),
	.oc_fault_status_out(oc_fault_status_out), .fault_notify_out(fault_notify_out),
	.attempt_count_out(attempt_count_out)
);

// ---- dv/ocfr_host_model.sv ----
`timescale 1ns/1ps
module ocfr_host_model (
	// Clock
	input  wire logic   clk_in,
	// Command port
	output logic        cmd_valid_out,
	output logic        cmd_write_out,
	output logic [7:0]  cmd_code_out,
	output logic [15:0] cmd_wdata_out
);
	initial begin
		cmd_valid_out = 1'b0;
		cmd_write_out = 1'b0;
		cmd_code_out  = 8'h00;
		cmd_wdata_out = 16'h0000;
	end

	task automatic send(input logic wr, input logic [7:0] code, input logic [15:0] data);
		@(negedge clk_in);
		cmd_valid_out = 1'b1;
		cmd_write_out = wr;
		cmd_code_out  = code;
		cmd_wdata_out = data;
		@(negedge clk_in);
		cmd_valid_out = 1'b0;
		// Released lines flip so stale values never pass
		cmd_write_out = ~wr;
		cmd_code_out  = ~code;
		cmd_wdata_out = ~data;
	endtask
endmodule

// ---- dv/ocfr_core_test.sv ----
`timescale 1ns/1ps
module ocfr_core_test import ocfr_pkg::*;;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	wire logic cmd_valid, cmd_write, rdata_valid, enable, limit_en, status;
	wire logic [7:0] cmd_code;
	wire logic [15:0] cmd_wdata, rdata, cur_thr, lv_thr;
	wire logic [2:0] attempts;
	logic status_clear = 0, clear_faults = 0, output_on = 0, other_fault = 0, oc = 0, limiting = 0, vout_low = 0;
	logic [15:0] unit_cycles = 16'h0002;
	logic [15:0] exp_q[$];
	logic [15:0] d[3];
	logic [7:0] t_resp[4] = '{8'h01, 8'h41, 8'h41, 8'h81};
	logic t_vlow[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
	logic t_en[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
	logic prev;
	int n_fail = 0, n_compared = 0, seed = 79165, rises, first, gap;

	ocfr_host_model ocfr_host_model_inst (.clk_in(clk_in), .cmd_valid_out(cmd_valid), .cmd_write_out(cmd_write),
		.cmd_code_out(cmd_code), .cmd_wdata_out(cmd_wdata));
	ocfr_core ocfr_core_inst (.clk_in(clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid), .cmd_write_in(cmd_write),
		.cmd_code_in(cmd_code), .cmd_wdata_in(cmd_wdata), .rdata_out(rdata), .rdata_valid_out(rdata_valid),
		.cmd_unsupported_out(), .status_clear_in(status_clear), .clear_faults_in(clear_faults),
		.output_on_cmd_in(output_on), .other_fault_in(other_fault), .unit_cycles_in(unit_cycles),
		.oc_detect_in(oc), .limiting_in(limiting), .vout_low_in(vout_low), .output_enable_out(enable),
		.current_limit_en_out(limit_en), .current_fault_threshold_out(cur_thr),
		.low_voltage_cutoff_threshold_out(lv_thr), .oc_fault_status_out(status), .fault_notify_out(),
		.attempt_count_out(attempts));

	// ----
	// Shared tasks
	// ----
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic bit_chk(input logic got, input logic exp, input string what);
		check({15'h0000, got}, {15'h0000, exp}, what);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	task automatic wr(input logic [7:0] code, input logic [15:0] data);
		ocfr_host_model_inst.send(1'b1, code, data);
	endtask
	task automatic rd(input logic [7:0] code, input logic [15:0] exp);
		exp_q.push_back(exp);
		ocfr_host_model_inst.send(1'b0, code, 16'h0000);
	endtask
	// Off-on cycle so every case starts from a clean fault state
	task automatic arm(input logic [7:0] resp);
		output_on = 1'b0;
		oc = 1'b0;
		limiting = 1'b0;
		vout_low = 1'b0;
		other_fault = 1'b0;
		cyc(2);
		wr(CMD_OC_RESPONSE, {8'h00, resp});
		output_on = 1'b1;
		cyc(3);
		bit_chk(status, 1'b0, "status after off-on");
	endtask
	task automatic complete_run();
		$display("Compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		forever #25 clk_in = ~clk_in;
	end
	always @(negedge clk_in) begin
		if (rdata_valid === 1'b1) begin
			if (exp_q.size() == 0)
				check(rdata, 16'hxxxx, "unexpected read data");
			else
				check(rdata, exp_q.pop_front(), "read data");
		end
	end
	// About six times the expected run
	initial begin
		#200000;
		n_fail++;
		$display("[FAIL] %0t watchdog expired", $time);
		complete_run();
	end

	// ----
	// Scenarios
	// ----
	initial begin
		cyc(2);
		rst_in = 1'b0;
		rd(CMD_OC_RESPONSE, {8'h00, RESPONSE_RESET});
		rd(CMD_CURRENT_LIMIT, CUR_LIMIT_RESET);
		rd(CMD_LV_CUTOFF, LV_CUTOFF_RESET);
		for (int i = 0; i < 3; i++) begin
			d[i] = 16'($random(seed));
			wr(CMD_CURRENT_LIMIT + 8'(i), d[i]);
			rd(CMD_CURRENT_LIMIT + 8'(i), (i == 1) ? {8'h00, d[i][7:0]} : d[i]);
		end
		check(cur_thr, d[0], "current threshold");
		check(lv_thr, d[2], "cutoff threshold");
		ocfr_host_model_inst.send(1'b1, 8'h99, 16'hffff);
		ocfr_host_model_inst.send(1'b0, 8'h99, 16'h0000);
		rd(CMD_CURRENT_LIMIT, d[0]);
		$display("Register test done");
		for (int r = 0; r < 8; r++) begin
			arm({2'h3, 3'(r), 3'h1});
			oc = 1'b1;
			rises = 0;
			first = 0;
			gap = 0;
			prev = 1'b1;
			for (int c = 1; c <= 60; c++) begin
				cyc(1);
				if (enable === 1'b1 && !prev) begin
					rises++;
					if (rises == 1)
						first = c;
					if (rises == 2)
						gap = c - first;
				end
				prev = enable;
			end
			bit_chk(status, 1'b1, "fault status");
			if (r < 7) begin
				check(16'(rises), 16'(r), "restart count");
				check({13'h0000, attempts}, 16'(r), "attempt count");
				bit_chk(enable, 1'b0, "output after retries");
			end else begin
				bit_chk(16'(rises) > 16'h0008, 1'b1, "endless restarts");
				other_fault = 1'b1;
				cyc(3);
				bit_chk(enable, 1'b0, "stopped by other fault");
			end
			if (r > 0)
				check(16'(first), 16'h0005, "first restart time");
			if (r > 1 && r < 7)
				check(16'(gap), 16'h0004, "restart spacing");
			oc = 1'b0;
			clear_faults = (r == 0);
			status_clear = (r == 1);
			cyc(1);
			clear_faults = 1'b0;
			status_clear = 1'b0;
			cyc(2);
			if (r < 2)
				bit_chk(enable, 1'b1, "running after clear");
		end
		$display("Retry test done");
		for (int i = 0; i < 4; i++) begin
			arm(t_resp[i]);
			oc = 1'b1;
			limiting = 1'b1;
			cyc(1);
			oc = 1'b0;
			cyc(2);
			bit_chk(enable, 1'b1, "running while limiting");
			bit_chk(limit_en, 1'b1, "limiting armed");
			vout_low = t_vlow[i];
			cyc(8);
			bit_chk(enable, t_en[i], "output after limiting");
		end
		// Clean restart: one unit off, one unit on without fault, then back to running
		arm({RESP_SHUTDOWN, 3'h2, 3'h0});
		oc = 1'b1;
		cyc(1);
		oc = 1'b0;
		cyc(6);
		bit_chk(enable, 1'b1, "running after restart");
		check({13'h0000, attempts}, 16'h0000, "attempts after success");
		$display("Response test done");
		cyc(2);
		check(16'(exp_q.size()), 16'h0000, "reads unanswered");
		complete_run();
	end
endmodule
